// file: bench/eris_irq_sink.sv
// Behavioural interrupt controller and message target that counts requests.
`timescale 1ns/1ps
module eris_irq_sink
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [2:0] i_pulse,
	input wire logic i_msi_req,
	output int o_cnt [4]
);
	// A pulse stands one cycle, so each high sample is one request; writes are always accepted.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_cnt <= '{default: 0};
		else
		begin
			for (int k = 0; k < 3; k++)
				o_cnt[k] <= o_cnt[k] + int'(i_pulse[k]);
			o_cnt[3] <= o_cnt[3] + int'(i_msi_req);
		end
	end
endmodule

// file: bench/eris_props.sv
// Checker of request timing and causes at the ports of the signaling top.
`timescale 1ns/1ps
module eris_props
	import eris_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_err_rst_n,
	input wire eris_pkg::eris_ctl_t [NREC-1:0] i_ctl,
	input wire eris_pkg::eris_evt_t [NREC-1:0] i_evt,
	input wire logic [NREC-1:0] i_clr,
	input wire eris_pkg::eris_rec_t [NREC-1:0] o_rec,
	input wire logic o_fault_irq,
	input wire logic o_recovery_irq,
	input wire logic o_critical_irq,
	input wire logic o_fault_pulse,
	input wire logic o_recovery_pulse,
	input wire logic o_critical_pulse,
	input wire logic [2:0] o_irq_state_reg
);
	logic fev, rev, cev, fl, rl, cl, u;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n || !i_err_rst_n);
	// Causes and stored conditions are ORed over records, since the requests are shared.
	always_comb
	begin
		fev = 1'b0;
		rev = 1'b0;
		cev = 1'b0;
		fl = 1'b0;
		rl = 1'b0;
		cl = 1'b0;
		u = 1'b0;
		for (int k = 0; k < NREC; k++)
		begin
			u = i_evt[k].ue | (i_evt[k].crit & ~i_ctl[k].crit_en);
			fev |= i_evt[k].valid & ((i_ctl[k].fault_due_en & (u | i_evt[k].de)) | (i_ctl[k].fault_ce_en & i_evt[k].ce));
			rev |= i_evt[k].valid & ((i_ctl[k].rec_ue_en & u) | (i_ctl[k].rec_de_en & i_evt[k].de));
			cev |= i_evt[k].valid & i_evt[k].crit & i_ctl[k].crit_en;
			fl |= o_rec[k].v & (o_rec[k].ue | o_rec[k].de | o_rec[k].of);
			rl |= o_rec[k].v & (o_rec[k].ue | o_rec[k].de);
			cl |= o_rec[k].v & o_rec[k].crit;
		end
	end
	sequence s_rec_quiet;
		rev ##1 (!(|i_clr) && $stable(i_ctl));
	endsequence
	property p_fault_lvl; o_fault_irq |-> fl; endproperty
	a_fault_lvl: assert property (p_fault_lvl) else $error("fault level without cause");
	property p_rec_lvl; o_recovery_irq |-> rl; endproperty
	a_rec_lvl: assert property (p_rec_lvl) else $error("recovery level without cause");
	property p_crit_lvl; o_critical_irq |-> cl; endproperty
	a_crit_lvl: assert property (p_crit_lvl) else $error("critical level without cause");
	property p_state; o_irq_state_reg == {o_critical_irq, o_recovery_irq, o_fault_irq}; endproperty
	a_state: assert property (p_state) else $error("state bits differ from levels");
	property p_fault_edge; fev |=> o_fault_pulse; endproperty
	a_fault_edge: assert property (p_fault_edge) else $error("fault pulse missing");
	property p_rec_edge; rev |=> o_recovery_pulse; endproperty
	a_rec_edge: assert property (p_rec_edge) else $error("recovery pulse missing");
	property p_crit_edge; cev |=> o_critical_pulse; endproperty
	a_crit_edge: assert property (p_crit_edge) else $error("critical pulse missing");
	property p_rec_hold; s_rec_quiet |=> o_recovery_irq; endproperty
	a_rec_hold: assert property (p_rec_hold) else $error("recovery level late");
endmodule
bind eris_top eris_props i_props (.i_clock, .i_rst_n, .i_err_rst_n, .i_ctl, .i_evt, .i_clr, .o_rec,
	.o_fault_irq, .o_recovery_irq, .o_critical_irq, .o_fault_pulse, .o_recovery_pulse, .o_critical_pulse,
	.o_irq_state_reg);

// file: bench/testbench.sv
// Self-checking bench for the signaling top.
`timescale 1ns/1ps
module testbench;
	import eris_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_err_rst_n = 1'b1;
	eris_ctl_t [NREC-1:0] ctl = '0;
	eris_evt_t [NREC-1:0] evt = '0;
	logic [NREC-1:0] clr = '0;
	logic [TS_W-1:0] sys_count = '0;
	logic [2:0] we = '0;
	eris_msi_t wd = '0;
	eris_rec_t [NREC-1:0] rec;
	eris_msi_t [2:0] cfg;
	logic [1:0] ts_src;
	logic [2:0] st;
	logic f_irq, r_irq, c_irq, f_p, r_p, c_p, mreq;
	logic [63:0] maddr;
	logic [31:0] mdata;
	int cnt [4];
	int err_total = 0;
	int checked = 0;
	always #12.5 i_clock = ~i_clock;
	// The system count moves so the sampler sees changing values.
	always @(negedge i_clock) sys_count <= sys_count + 64'h1;
	eris_top i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_err_rst_n(i_err_rst_n), .i_ctl(ctl), .i_evt(evt),
		.i_clr(clr), .i_sys_count(sys_count), .i_msi_we(we), .i_msi_wdata(wd), .o_rec(rec), .o_msi_cfg(cfg),
		.o_timestamp_feature_field(ts_src), .o_fault_irq(f_irq), .o_recovery_irq(r_irq), .o_critical_irq(c_irq),
		.o_fault_pulse(f_p), .o_recovery_pulse(r_p), .o_critical_pulse(c_p), .o_irq_state_reg(st),
		.o_msi_req(mreq), .o_msi_addr(maddr), .o_msi_data(mdata));
	eris_irq_sink i_sink (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pulse({c_p, r_p, f_p}), .i_msi_req(mreq),
		.o_cnt(cnt));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// One recording: the valid pulse is sampled at the single edge between two falling edges.
	task automatic ev(input int r, input logic [5:0] e);
		@(negedge i_clock);
		evt[r] = e;
		@(negedge i_clock);
		evt[r] = '0;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog sized well above the roughly 560 cycles the sequence needs.
	initial
	begin
		#100000;
		err_total++;
		$display("[ERR] t=%0t watchdog expired", $time);
		close_out();
	end
	initial
	begin
		tick(2);
		i_rst_n = 1'b1;
		wd = {64'h1000_0040, 32'hcafe_0001, 8'hcb};
		we = 3'h1;
		tick(1);
		we = 3'h0;
		tick(2);
		chk(cfg[0].addr, 64'h1000_0040);
		chk(cfg[0].data, 64'hcafe_0001);
		chk({cfg[0].en, cfg[0].sh, cfg[0].memattr, cfg[0].ns}, 64'hcb);
		ctl[1] = 5'h1f;
		tick(2);
		ev(1, 6'h30);
		chk({f_p, r_p, c_p, mreq}, 64'hd);
		chk(maddr, 64'h1000_0040);
		tick(2);
		chk({f_irq, r_irq, c_irq, st, rec[1].v, rec[1].ue}, 64'hcf);
		$display("test uncorrected done");
		// Critical flag set twice on one record; a disabled record takes it as uncorrected.
		ctl[2] = 5'h1f;
		ctl[0] = 5'h04;
		tick(2);
		ev(2, 6'h22);
		ev(0, 6'h22);
		ev(2, 6'h22);
		tick(2);
		chk(cnt[2], 2);
		chk(cnt[1], 2);
		chk(cnt[3], 2);
		chk(mdata, 64'hcafe_0001);
		chk({rec[0].ue, rec[0].crit, c_irq}, 64'h7);
		chk(rec[0].ts - rec[2].ts, 64'h2);
		chk(ts_src, 64'h2);
		$display("test critical done");
		clr = 4'hf;
		tick(1);
		clr = 4'h0;
		tick(2);
		chk({f_irq, r_irq, c_irq, rec[1].v}, 64'h0);
		// Corrected counts raise no level until the counter wraps.
		ctl[3] = 5'h08;
		tick(1);
		repeat (255) ev(3, 6'h24);
		tick(2);
		chk({f_irq, rec[3].of, rec[3].cnt}, 64'hff);
		chk(cnt[0], 256);
		ev(3, 6'h24);
		tick(2);
		chk({f_irq, rec[3].of}, 64'h3);
		$display("test counter done");
		ev(1, 6'h28);
		tick(2);
		chk(r_irq, 64'h1);
		// Dropping and restoring the deferred recovery enable pulses once on restore.
		ctl[1] = 5'h1d;
		tick(2);
		ctl[1] = 5'h1f;
		tick(1);
		chk({f_p, r_p}, 64'h1);
		i_err_rst_n = 1'b0;
		tick(2);
		chk({r_irq, r_p}, 64'h0);
		i_err_rst_n = 1'b1;
		tick(3);
		chk({rec[1].v, rec[1].de, cfg[0].en, r_irq}, 64'hf);
		i_rst_n = 1'b0;
		tick(2);
		i_rst_n = 1'b1;
		tick(2);
		chk({rec[1].v, rec[3].of, cfg[0].en, r_irq}, 64'h0);
		$display("test resets done");
		close_out();
	end
endmodule

// file: rtl/eris_record.sv
// One error record with its syndrome, counter, timestamp and request logic.
`timescale 1ns/1ps
module eris_record
	import eris_pkg::*;
#(
	parameter bit HAS_COUNTER = 1'b1,
	parameter bit HAS_CRIT = 1'b1,
	parameter bit HAS_TS = 1'b1,
	parameter bit EDGE_ON_ENABLE = 1'b1
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_err_rst_n,
	input wire eris_pkg::eris_ctl_t i_ctl,
	input wire eris_pkg::eris_evt_t i_evt,
	input wire logic i_clr,
	input wire logic [TS_W-1:0] i_ts,
	output eris_pkg::eris_rec_t o_rec,
	output logic o_fault_lvl,
	output logic o_rec_lvl,
	output logic o_crit_lvl,
	output logic o_fault_edge,
	output logic o_rec_edge,
	output logic o_crit_edge
);
	import eris_pkg::*;

	eris_rec_t rec_q;
	eris_ctl_t ctl_q;
	logic ue_in;
	logic [CNT_W:0] cnt_sum;
	logic lvl_f;
	logic lvl_r;
	logic lvl_c;
	logic lf_q;
	logic lr_q;
	logic lc_q;
	logic hist_q;

	// A disabled critical condition is recorded as uncontainable, hence uncorrected.
	assign ue_in = i_evt.ue | i_evt.uncontainable | (i_evt.crit & ~(HAS_CRIT & i_ctl.crit_en));
	assign cnt_sum = {1'b0, rec_q.cnt} + {{CNT_W{1'b0}}, 1'b1};

	// Syndrome storage is reset only by Cold reset so recovery software can read it.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rec_q <= '0;
		else if (i_evt.valid)
		begin
			rec_q.v <= 1'b1;
			// A higher priority error already held is kept; flags only accumulate.
			rec_q.ue <= rec_q.ue | ue_in;
			rec_q.de <= rec_q.de | i_evt.de;
			rec_q.crit <= rec_q.crit | (HAS_CRIT & i_evt.crit);
			if (HAS_TS && !rec_q.v)
				rec_q.ts <= i_ts;
			if (i_evt.ce && HAS_COUNTER)
			begin
				rec_q.cnt <= cnt_sum[CNT_W-1:0];
				if (cnt_sum[CNT_W])
					rec_q.of <= 1'b1;
			end
			else if (i_evt.ce && rec_q.ce != '1)
				rec_q.ce <= rec_q.ce + {{(CE_W-1){1'b0}}, 1'b1};
		end
		else if (i_clr)
		begin
			rec_q.v <= 1'b0;
			rec_q.ue <= 1'b0;
			rec_q.de <= 1'b0;
			rec_q.crit <= 1'b0;
			rec_q.of <= 1'b0;
			rec_q.ce <= '0;
		end
	end

	// Level conditions from the stored syndrome.
	assign lvl_f = (i_ctl.fault_due_en & rec_q.v & (rec_q.de | rec_q.ue))
		| (i_ctl.fault_ce_en & rec_q.v & (HAS_COUNTER ? rec_q.of : (rec_q.ce != '0)));
	assign lvl_r = rec_q.v & ((rec_q.ue & i_ctl.rec_ue_en) | (rec_q.de & i_ctl.rec_de_en));
	assign lvl_c = HAS_CRIT & i_ctl.crit_en & rec_q.v & rec_q.crit;

	// Previous levels and enables are control state, cleared by either reset.
	always_ff @(posedge i_clock or negedge i_err_rst_n)
	begin
		if (!i_err_rst_n)
		begin
			lf_q <= 1'b0;
			lr_q <= 1'b0;
			lc_q <= 1'b0;
			ctl_q <= '0;
			hist_q <= 1'b0;
		end
		else
		begin
			lf_q <= lvl_f;
			lr_q <= lvl_r;
			lc_q <= lvl_c;
			ctl_q <= i_ctl;
			hist_q <= 1'b1;
		end
	end

	// Edge pulses fire on every enabled recording even when the syndrome is discarded.
	always_comb
	begin
		o_fault_edge = i_evt.valid & ((i_ctl.fault_due_en & (ue_in | i_evt.de))
			| (i_ctl.fault_ce_en & i_evt.ce));
		o_rec_edge = i_evt.valid & ((i_ctl.rec_ue_en & ue_in) | (i_ctl.rec_de_en & i_evt.de));
		o_crit_edge = HAS_CRIT & i_evt.valid & i_ctl.crit_en & i_evt.crit;
		// An enable write that creates a level condition also pulses.
		// History is trusted only a cycle after reset, so a reset never looks like a write.
		if (EDGE_ON_ENABLE && hist_q && (ctl_q != i_ctl))
		begin
			o_fault_edge = o_fault_edge | (lvl_f & ~lf_q);
			o_rec_edge = o_rec_edge | (lvl_r & ~lr_q);
			o_crit_edge = o_crit_edge | (lvl_c & ~lc_q);
		end
	end

	assign o_rec = rec_q;
	assign o_fault_lvl = lvl_f;
	assign o_rec_lvl = lvl_r;
	assign o_crit_lvl = lvl_c;
endmodule

// file: rtl/eris_top.sv
// Top of the error record interrupt signaling block with shared requests and message config.
`timescale 1ns/1ps
module eris_top
	import eris_pkg::*;
#(
	parameter bit HAS_MSI = 1'b1,
	parameter bit USE_SYS_TIMER = 1'b0
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_err_rst_n,
	input wire eris_pkg::eris_ctl_t [NREC-1:0] i_ctl,
	input wire eris_pkg::eris_evt_t [NREC-1:0] i_evt,
	input wire logic [NREC-1:0] i_clr,
	input wire logic [TS_W-1:0] i_sys_count,
	input wire logic [2:0] i_msi_we,
	input wire eris_pkg::eris_msi_t i_msi_wdata,
	output eris_pkg::eris_rec_t [NREC-1:0] o_rec,
	output eris_pkg::eris_msi_t [2:0] o_msi_cfg,
	output logic [1:0] o_timestamp_feature_field,
	output logic o_fault_irq,
	output logic o_recovery_irq,
	output logic o_critical_irq,
	output logic o_fault_pulse,
	output logic o_recovery_pulse,
	output logic o_critical_pulse,
	output logic [2:0] o_irq_state_reg,
	output logic o_msi_req,
	output logic [63:0] o_msi_addr,
	output logic [31:0] o_msi_data
);
	import eris_pkg::*;

	eris_rec_t [NREC-1:0] rec_w;
	logic [NREC-1:0] fl_w;
	logic [NREC-1:0] rl_w;
	logic [NREC-1:0] cl_w;
	logic [NREC-1:0] fe_w;
	logic [NREC-1:0] re_w;
	logic [NREC-1:0] ce_w;
	logic [TS_W-1:0] sys_s1_q;
	logic [TS_W-1:0] sys_s2_q;
	logic [TS_W-1:0] sys_s3_q;
	logic [TS_W-1:0] sys_ok_q;
	logic [TS_W-1:0] tb_q;
	logic [31:0] div_q;
	logic [TS_W-1:0] ts_w;
	eris_msi_t [2:0] msi_q;
	logic [2:0] pend_q;
	logic [2:0] edge_w;
	logic [2:0] lvl_w;
	logic [2:0] msi_ev_w;
	logic [2:0] pend_d;
	logic [2:0] grant_w;
	logic tb_tick;
	logic erst_n;

	// Control state of records and requests falls to either reset, so a Cold reset clears it too.
	assign erst_n = i_err_rst_n & i_rst_n;

	// Sample the system counter through two stages, it comes from another domain.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sys_s1_q <= TS_RST;
			sys_s2_q <= TS_RST;
			sys_s3_q <= TS_RST;
		end
		else
		begin
			sys_s1_q <= i_sys_count;
			sys_s2_q <= sys_s1_q;
			sys_s3_q <= sys_s2_q;
		end
	end

	// A raw count may be caught mid-change in some bits; a sample is kept only when it matches
	// the one before or is one step on, otherwise the last good value stands.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			sys_ok_q <= TS_RST;
		else if ((sys_s2_q == sys_s3_q) || (sys_s2_q == sys_s3_q + 64'h1))
			sys_ok_q <= sys_s2_q;
	end

	// Divider for the own timebase: a one-cycle enable every TS_DIV clocks.
	assign tb_tick = (div_q + 32'h1 >= TS_DIV);

	// Divider count, restarting at each enable.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			div_q <= '0;
		else if (tb_tick)
			div_q <= '0;
		else
			div_q <= div_q + 32'h1;
	end

	// Own timebase: a plain binary count, one step per divider enable.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			tb_q <= TS_RST;
		else if (tb_tick)
			tb_q <= tb_q + 64'h1;
	end

	// The filtered count suits a source that moves at most one step per clock; a faster one needs gray code.
	assign ts_w = USE_SYS_TIMER ? sys_ok_q : tb_q;

	// One record instance per error record.
	generate
		for (genvar g = 0; g < NREC; g++)
		begin : g_rec
			eris_record u_rec (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_err_rst_n(erst_n),
				.i_ctl(i_ctl[g]),
				.i_evt(i_evt[g]),
				.i_clr(i_clr[g]),
				.i_ts(ts_w),
				.o_rec(rec_w[g]),
				.o_fault_lvl(fl_w[g]),
				.o_rec_lvl(rl_w[g]),
				.o_crit_lvl(cl_w[g]),
				.o_fault_edge(fe_w[g]),
				.o_rec_edge(re_w[g]),
				.o_crit_edge(ce_w[g])
			);
		end
	endgenerate

	// Requests shared by all records: bit 0 fault, bit 1 recovery, bit 2 critical.
	// One OR per class keeps routing simple, at the price of not telling records apart.
	assign edge_w = {|ce_w, |re_w, |fe_w};
	assign lvl_w = {|cl_w, |rl_w, |fl_w};

	// Level requests, registered so they settle one cycle after the record changes.
	// Registering costs a cycle of latency but keeps the request pins free of glitches.
	always_ff @(posedge i_clock or negedge erst_n)
	begin
		if (!erst_n)
		begin
			o_fault_irq <= 1'b0;
			o_recovery_irq <= 1'b0;
			o_critical_irq <= 1'b0;
		end
		else
		begin
			o_fault_irq <= lvl_w[0];
			o_recovery_irq <= lvl_w[1];
			o_critical_irq <= lvl_w[2];
		end
	end

	// Edge requests stand for exactly one cycle per recording or enabling write.
	always_ff @(posedge i_clock or negedge erst_n)
	begin
		if (!erst_n)
		begin
			o_fault_pulse <= 1'b0;
			o_recovery_pulse <= 1'b0;
			o_critical_pulse <= 1'b0;
		end
		else
		begin
			o_fault_pulse <= edge_w[0];
			o_recovery_pulse <= edge_w[1];
			o_critical_pulse <= edge_w[2];
		end
	end

	// The status view mirrors the three levels so software may poll instead of taking a request.
	always_ff @(posedge i_clock or negedge erst_n)
	begin
		if (!erst_n)
			o_irq_state_reg <= '0;
		else
			o_irq_state_reg <= lvl_w;
	end

	// Record view, registered so every top output comes from a flop; it trails the records by a cycle.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rec <= '0;
		else
			o_rec <= rec_w;
	end

	// Timebase source shown to software; it reads as none while Cold reset holds.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_timestamp_feature_field <= TS_SRC_NONE;
		else
			o_timestamp_feature_field <= USE_SYS_TIMER ? TS_SRC_SYS : TS_SRC_IMP;
	end

	// Message configuration: 0 recovery, 1 fault, 2 critical; zero and inert when absent.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			msi_q <= '0;
		else if (HAS_MSI)
		begin
			for (int k = 0; k < 3; k++)
				if (i_msi_we[k])
					msi_q[k] <= i_msi_wdata;
		end
	end

	// Configuration readback; it reads as zero when messages are not built in.
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_msi_cfg <= '0;
		else
			o_msi_cfg <= HAS_MSI ? msi_q : '0;
	end

	// Edges reordered to the message types: 0 recovery, 1 fault, 2 critical.
	assign msi_ev_w = {edge_w[2], edge_w[0], edge_w[1]};

	// Next pending set; a type whose message is disabled is never queued.
	always_comb
	begin
		pend_d = pend_q;
		for (int k = 0; k < 3; k++)
			if (msi_ev_w[k] && HAS_MSI && msi_q[k].en)
				pend_d[k] = 1'b1;
	end

	// One write per cycle, recovery first; a later type waits in its pending bit, so none is lost.
	always_comb
	begin
		grant_w = 3'h0;
		if (pend_d[0])
			grant_w = 3'h1;
		else if (pend_d[1])
			grant_w = 3'h2;
		else if (pend_d[2])
			grant_w = 3'h4;
	end

	// Pending bits are control state and fall to the recovery reset.
	always_ff @(posedge i_clock or negedge erst_n)
	begin
		if (!erst_n)
			pend_q <= '0;
		else
			pend_q <= pend_d & ~grant_w;
	end

	// Message write: address and data of the granted type, with a one-cycle request strobe.
	always_ff @(posedge i_clock or negedge erst_n)
	begin
		if (!erst_n)
		begin
			o_msi_req <= 1'b0;
			o_msi_addr <= '0;
			o_msi_data <= MSI_RST;
		end
		else
		begin
			o_msi_req <= |grant_w;
			for (int k = 0; k < 3; k++)
				if (grant_w[k])
				begin
					o_msi_addr <= msi_q[k].addr;
					o_msi_data <= msi_q[k].data;
				end
		end
	end
endmodule

// file: shared/eris_pkg.sv
// Package with constants and carrier types for the error record interrupt signaling block.
package eris_pkg;
	localparam int unsigned NREC = 4;
	localparam int unsigned CE_W = 2;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned TS_W = 64;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
	localparam logic [TS_W-1:0] TS_RST = 64'h0;
	localparam logic [31:0] MSI_RST = 32'h0;
	localparam logic [1:0] TS_SRC_NONE = 2'h0;
	localparam logic [1:0] TS_SRC_SYS = 2'h1;
	localparam logic [1:0] TS_SRC_IMP = 2'h2;
	localparam logic [31:0] TS_DIV = 32'h00000001;

	// Per record control enables written by software.
	typedef struct packed {
		logic fault_due_en;
		logic fault_ce_en;
		logic rec_ue_en;
		logic rec_de_en;
		logic crit_en;
	} eris_ctl_t;

	// One recording event from the detecting logic.
	typedef struct packed {
		logic valid;
		logic ue;
		logic de;
		logic ce;
		logic crit;
		logic uncontainable;
	} eris_evt_t;

	// Stored syndrome of one record.
	typedef struct packed {
		logic v;
		logic ue;
		logic de;
		logic crit;
		logic of;
		logic [CE_W-1:0] ce;
		logic [CNT_W-1:0] cnt;
		logic [TS_W-1:0] ts;
	} eris_rec_t;

	// One message-signaled configuration triple.
	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] data;
		logic en;
		logic [1:0] sh;
		logic [3:0] memattr;
		logic ns;
	} eris_msi_t;
endpackage
